// *** inc/icm_cfg.svh ***
`ifndef ICM_CFG_SVH
`define ICM_CFG_SVH

// =============================================
// Bus geometry
`define ICM_ADDR_W 8
`define ICM_MSG_W 24

// =============================================
// Register byte offsets, one map per core
`define ICM_OFF_PEER_NMI_STATUS_MIRROR 8'h00
`define ICM_OFF_MASKABLE_MSG_DATA_OUT 8'h04
`define ICM_OFF_MASKABLE_MSG_CONTROL 8'h08
`define ICM_OFF_MASKABLE_SERVICE_CONFIRM 8'h0C
`define ICM_OFF_MASKABLE_MSG_DATA_IN 8'h10
`define ICM_OFF_PEER_MASKABLE_CONTROL_MIRROR 8'h14
`define ICM_OFF_IRQ_STATUS 8'h20
`define ICM_OFF_IRQ_CLEAR 8'h24
`define ICM_OFF_IRQ_ENABLE 8'h28

// =============================================
// Field positions
`define ICM_BIT_DATA_SLOT_EMPTY 2
`define ICM_BIT_NMI_PENDING 1
`define ICM_BIT_ERROR_IRQ_ENABLE 3
`define ICM_BIT_ERROR_FLAG 2
`define ICM_BIT_MASKABLE_PENDING_FLAG 1
`define ICM_BIT_MASKABLE_IRQ_ENABLE 0
`define ICM_BIT_SERVICED_FLAG_CLEAR 1
`define ICM_BIT_SERVICED_FLAG 0
`define ICM_BIT_IRQ_MSG 0
`define ICM_BIT_IRQ_ACK 1
`define ICM_BIT_IRQ_ERR 2
`define ICM_IRQ_W 3

// =============================================
// Reset values and responses
`define ICM_RST_MSG 24'h000000
`define ICM_RST_IRQ 3'h0
`define ICM_RESP_OKAY 2'h0
`define ICM_RESP_SLVERR 2'h2

`endif

// *** inc/icm_pkg.sv ***
`default_nettype none
`include "icm_cfg.svh"

package icm_pkg;

    // =============================================
    // AXI4-Lite carriers, master to slave and back
    typedef struct packed {
        logic awvalid;
        logic [`ICM_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`ICM_ADDR_W-1:0] araddr;
        logic rready;
    } icm_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } icm_axi_resp_t;

endpackage

`default_nettype wire

// *** design/icm_mailbox.sv ***
// What this block does
// - peer nmi mirror bit 2 shows the other core's data slot empty flag.
// - peer nmi mirror bit 1 shows the other core's nmi pending flag.
// - writing the 24-bit outgoing message raises a maskable interrupt to the peer, unless the peer reads incoming data in the same cycle.
// - control bit 3 enables the error interrupt; at 0 it is suppressed.
// - control bit 2 is the error flag, set on error, cleared by writing 1.
// - control bit 1 is the local pending flag, 1 while a condition is present.
// - control bit 0 enables delivery of the maskable interrupt to the peer.
// - writing 1 to confirm bit 1 clears the serviced flag in bit 0.
// - confirm bit 0 becomes 1 once the peer has serviced the message.
// - incoming data register is read-only and returns the peer's 24-bit message.
// - peer control mirror bit 3 shows the peer's error interrupt enable.
// - peer control mirror bit 2 shows the peer's error flag.
// - peer control mirror bit 1 shows the peer's pending flag.
// - peer control mirror bit 0 shows the peer's maskable interrupt enable.
// - a write to the outgoing message sets the writer's pending flag, unless the peer reads incoming data in the same cycle.
// - reading incoming data clears sender pending; without a same-cycle write it also sets sender ack and interrupts sender.
// - same-cycle write and peer read: reader gets error, pending stays clear.
`default_nettype none
`include "icm_cfg.svh"

module icm_mailbox
    import icm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire icm_axi_req_t [1:0] axi_req,
    output icm_axi_resp_t [1:0] axi_resp,
    input wire logic [1:0] nmi_data_slot_empty,
    input wire logic [1:0] nmi_pending,
    output logic [1:0] irq
);

    // =============================================
    // Helpers
    function automatic logic icm_mapped(input logic [`ICM_ADDR_W-1:0] a);
        unique case (a)
            `ICM_OFF_PEER_NMI_STATUS_MIRROR,
            `ICM_OFF_MASKABLE_MSG_DATA_OUT,
            `ICM_OFF_MASKABLE_MSG_CONTROL,
            `ICM_OFF_MASKABLE_SERVICE_CONFIRM,
            `ICM_OFF_MASKABLE_MSG_DATA_IN,
            `ICM_OFF_PEER_MASKABLE_CONTROL_MIRROR,
            `ICM_OFF_IRQ_STATUS,
            `ICM_OFF_IRQ_CLEAR,
            `ICM_OFF_IRQ_ENABLE: icm_mapped = 1'b1;
            default: icm_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] icm_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        icm_merge = r;
    endfunction

    // =============================================
    // Shared state of both cores
    logic [`ICM_MSG_W-1:0] msg_out [2];
    logic [1:0] maskable_irq_enable;
    logic [1:0] error_irq_enable;
    logic [1:0] efl;
    logic [1:0] pend;
    logic [1:0] ack;
    logic [`ICM_IRQ_W-1:0] irq_sts [2];
    logic [`ICM_IRQ_W-1:0] irq_en [2];
    logic [1:0] wr_msg;
    logic [1:0] rd_in;
    logic [1:0] err;

    genvar c;
    generate
        for (c = 0; c < 2; c++)
        begin : g_core
            localparam int P = 1 - c;

            // =============================================
            // AXI4-Lite slave
            logic aw_held;
            logic w_held;
            logic [`ICM_ADDR_W-1:0] aw_addr;
            logic [31:0] w_data;
            logic [3:0] w_strb;
            logic bvalid;
            logic [1:0] bresp;
            logic rvalid;
            logic [31:0] rdata;
            logic [1:0] rresp;
            logic awready;
            logic wready;
            logic arready;
            logic wr_fire;
            logic rd_fire;
            logic wr_ctrl;
            logic wr_conf;
            logic [31:0] next_rdata;

            assign awready = !aw_held && !bvalid;
            assign wready = !w_held && !bvalid;
            assign arready = !rvalid;
            assign wr_fire = aw_held && w_held && !bvalid;
            assign rd_fire = axi_req[c].arvalid && arready;
            assign wr_ctrl = wr_fire && aw_addr == `ICM_OFF_MASKABLE_MSG_CONTROL && w_strb[0];
            assign wr_conf = wr_fire && aw_addr == `ICM_OFF_MASKABLE_SERVICE_CONFIRM && w_strb[0];

            assign wr_msg[c] = wr_fire && aw_addr == `ICM_OFF_MASKABLE_MSG_DATA_OUT;
            assign rd_in[c] = rd_fire && axi_req[c].araddr == `ICM_OFF_MASKABLE_MSG_DATA_IN;
            assign err[c] = rd_in[c] && wr_msg[P];

            assign axi_resp[c].awready = awready;
            assign axi_resp[c].wready = wready;
            assign axi_resp[c].bvalid = bvalid;
            assign axi_resp[c].bresp = bresp;
            assign axi_resp[c].arready = arready;
            assign axi_resp[c].rvalid = rvalid;
            assign axi_resp[c].rdata = rdata;
            assign axi_resp[c].rresp = rresp;

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    aw_held <= 1'b0;
                    aw_addr <= '0;
                end
                else if (axi_req[c].awvalid && awready)
                begin
                    aw_held <= 1'b1;
                    aw_addr <= axi_req[c].awaddr;
                end
                else if (wr_fire)
                    aw_held <= 1'b0;
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    w_held <= 1'b0;
                    w_data <= '0;
                    w_strb <= '0;
                end
                else if (axi_req[c].wvalid && wready)
                begin
                    w_held <= 1'b1;
                    w_data <= axi_req[c].wdata;
                    w_strb <= axi_req[c].wstrb;
                end
                else if (wr_fire)
                    w_held <= 1'b0;
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    bvalid <= 1'b0;
                    bresp <= `ICM_RESP_OKAY;
                end
                else if (wr_fire)
                begin
                    bvalid <= 1'b1;
                    bresp <= icm_mapped(aw_addr) ? `ICM_RESP_OKAY : `ICM_RESP_SLVERR;
                end
                else if (axi_req[c].bready)
                    bvalid <= 1'b0;
            end

            // Read mux, reserved and write-only bits read zero
            always_comb
            begin
                next_rdata = 32'h00000000;
                unique case (axi_req[c].araddr)
                    `ICM_OFF_PEER_NMI_STATUS_MIRROR:
                    begin
                        next_rdata[`ICM_BIT_DATA_SLOT_EMPTY] = nmi_data_slot_empty[P];
                        next_rdata[`ICM_BIT_NMI_PENDING] = nmi_pending[P];
                    end
                    `ICM_OFF_MASKABLE_MSG_CONTROL:
                    begin
                        next_rdata[`ICM_BIT_ERROR_IRQ_ENABLE] = error_irq_enable[c];
                        next_rdata[`ICM_BIT_ERROR_FLAG] = efl[c];
                        next_rdata[`ICM_BIT_MASKABLE_PENDING_FLAG] = pend[c];
                        next_rdata[`ICM_BIT_MASKABLE_IRQ_ENABLE] = maskable_irq_enable[c];
                    end
                    `ICM_OFF_MASKABLE_SERVICE_CONFIRM:
                        next_rdata[`ICM_BIT_SERVICED_FLAG] = ack[c];
                    `ICM_OFF_MASKABLE_MSG_DATA_IN:
                        next_rdata[`ICM_MSG_W-1:0] = msg_out[P];
                    `ICM_OFF_PEER_MASKABLE_CONTROL_MIRROR:
                    begin
                        next_rdata[`ICM_BIT_ERROR_IRQ_ENABLE] = error_irq_enable[P];
                        next_rdata[`ICM_BIT_ERROR_FLAG] = efl[P];
                        next_rdata[`ICM_BIT_MASKABLE_PENDING_FLAG] = pend[P];
                        next_rdata[`ICM_BIT_MASKABLE_IRQ_ENABLE] = maskable_irq_enable[P];
                    end
                    `ICM_OFF_IRQ_STATUS:
                        next_rdata[`ICM_IRQ_W-1:0] = irq_sts[c];
                    `ICM_OFF_IRQ_ENABLE:
                        next_rdata[`ICM_IRQ_W-1:0] = irq_en[c];
                    default:
                        next_rdata = 32'h00000000;
                endcase
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    rvalid <= 1'b0;
                    rdata <= 32'h00000000;
                    rresp <= `ICM_RESP_OKAY;
                end
                else if (rd_fire)
                begin
                    rvalid <= 1'b1;
                    rdata <= next_rdata;
                    rresp <= icm_mapped(axi_req[c].araddr) ? `ICM_RESP_OKAY : `ICM_RESP_SLVERR;
                end
                else if (axi_req[c].rready)
                    rvalid <= 1'b0;
            end

            // =============================================
            // Mailbox registers
            logic [31:0] merged_msg;

            assign merged_msg = icm_merge({8'h00, msg_out[c]}, w_data, w_strb);

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    msg_out[c] <= `ICM_RST_MSG;
                else if (wr_msg[c])
                    msg_out[c] <= merged_msg[`ICM_MSG_W-1:0];
            end

            // Only low control bits are stored; upper written bits dropped
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    maskable_irq_enable[c] <= 1'b0;
                    error_irq_enable[c] <= 1'b0;
                end
                else if (wr_ctrl)
                begin
                    maskable_irq_enable[c] <= w_data[`ICM_BIT_MASKABLE_IRQ_ENABLE];
                    error_irq_enable[c] <= w_data[`ICM_BIT_ERROR_IRQ_ENABLE];
                end
            end

            // Set wins over the write-one clear
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    efl[c] <= 1'b0;
                else if (err[c])
                    efl[c] <= 1'b1;
                else if (wr_ctrl && w_data[`ICM_BIT_ERROR_FLAG])
                    efl[c] <= 1'b0;
            end

            // Collision with the peer's read leaves the flag clear
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    pend[c] <= 1'b0;
                else if (wr_msg[c] && !rd_in[P])
                    pend[c] <= 1'b1;
                else if (rd_in[P])
                    pend[c] <= 1'b0;
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    ack[c] <= 1'b0;
                else if (rd_in[P] && !err[P])
                    ack[c] <= 1'b1;
                else if (wr_conf && w_data[`ICM_BIT_SERVICED_FLAG_CLEAR])
                    ack[c] <= 1'b0;
            end

            // =============================================
            // Interrupt status, clear and enable
            logic [`ICM_IRQ_W-1:0] ev;
            logic [`ICM_IRQ_W-1:0] clr;

            always_comb
            begin
                ev = `ICM_RST_IRQ;
                ev[`ICM_BIT_IRQ_MSG] = wr_msg[P] && !rd_in[c] && maskable_irq_enable[P];
                ev[`ICM_BIT_IRQ_ACK] = rd_in[P] && !err[P];
                ev[`ICM_BIT_IRQ_ERR] = err[c] && error_irq_enable[c];
            end

            assign clr = (wr_fire && aw_addr == `ICM_OFF_IRQ_CLEAR && w_strb[0]) ?
                         w_data[`ICM_IRQ_W-1:0] : `ICM_RST_IRQ;

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    irq_sts[c] <= `ICM_RST_IRQ;
                else
                    irq_sts[c] <= (irq_sts[c] & ~clr) | ev;
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    irq_en[c] <= `ICM_RST_IRQ;
                else if (wr_fire && aw_addr == `ICM_OFF_IRQ_ENABLE && w_strb[0])
                    irq_en[c] <= w_data[`ICM_IRQ_W-1:0];
            end

            assign irq[c] = |(irq_sts[c] & irq_en[c]);
        end
    endgenerate

endmodule

`default_nettype wire

// *** verif/icm_mailbox_monitor.sv ***
`default_nettype none
`include "icm_cfg.svh"

// =============================================
// Bus and mirror checks on core 0's port
module icm_mailbox_monitor
    import icm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire icm_axi_req_t [1:0] axi_req,
    input wire icm_axi_resp_t [1:0] axi_resp,
    input wire logic [1:0] nmi_data_slot_empty,
    input wire logic [1:0] nmi_pending,
    input wire logic [1:0] irq
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_rd_take;
        axi_req[0].arvalid && axi_resp[0].arready;
    endsequence

    sequence s_wr_take;
        axi_req[0].awvalid && axi_resp[0].awready && axi_req[0].wvalid && axi_resp[0].wready;
    endsequence

    a_read_answer: assert property (s_rd_take |=> axi_resp[0].rvalid)
        else $error("read answer missing");
    a_write_answer: assert property (s_wr_take |-> ##2 axi_resp[0].bvalid)
        else $error("write answer missing");
    a_read_holds: assert property (axi_resp[0].rvalid && !axi_req[0].rready |=> $stable(axi_resp[0].rdata))
        else $error("read data moved");
    a_resp_holds: assert property (axi_resp[0].bvalid && !axi_req[0].bready |=> axi_resp[0].bvalid)
        else $error("write answer dropped");
    a_nmi_mirror: assert property (s_rd_take ##0 (axi_req[0].araddr == 8'h00) |=>
        axi_resp[0].rdata == {29'h0, $past(nmi_data_slot_empty[1]), $past(nmi_pending[1]), 1'b0})
        else $error("nmi mirror wrong");
    a_reserved_zero: assert property (axi_resp[0].rvalid |-> axi_resp[0].rdata[31:24] == 8'h00)
        else $error("reserved bits set");
    a_unmapped_err: assert property (s_rd_take ##0 (axi_req[0].araddr == 8'h30) |=>
        axi_resp[0].rresp == `ICM_RESP_SLVERR && axi_resp[0].rdata == 32'h0)
        else $error("unmapped read accepted");
    a_read_refused: assert property (axi_resp[0].rvalid |-> !axi_resp[0].arready)
        else $error("address taken while answering");
endmodule

bind icm_mailbox icm_mailbox_monitor i_icm_mailbox_monitor (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_resp(axi_resp), .nmi_data_slot_empty(nmi_data_slot_empty), .nmi_pending(nmi_pending), .irq(irq));

`default_nettype wire

// *** verif/icm_peer_nmi.sv ***
`default_nettype none

// =============================================
// Non-maskable side of each core
module icm_peer_nmi
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] fill,
    input wire logic [1:0] serve,
    output logic [1:0] slot_empty,
    output logic [1:0] pending
);
    timeunit 1ns;
    timeprecision 100ps;

    // A datum lands only while the slot is empty
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            slot_empty <= 2'h3;
            pending <= 2'h0;
        end
        else
        begin
            slot_empty <= (slot_empty & ~fill) | serve;
            pending <= (pending | (fill & slot_empty)) & ~serve;
        end
endmodule

`default_nettype wire

// *** verif/icm_mailbox_tb_top.sv ***
`default_nettype none
`include "icm_cfg.svh"

module icm_mailbox_tb_top
    import icm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk;
    logic aresetn;
    icm_axi_req_t [1:0] req;
    icm_axi_resp_t [1:0] resp;
    logic [1:0] fill;
    logic [1:0] serve;
    logic [1:0] slot_empty;
    logic [1:0] pending;
    logic [1:0] irq;
    logic [31:0] rdat;
    logic [1:0] rsp;
    int bad_count;
    int n_compared;
    int cycles;

    icm_peer_nmi i_icm_peer_nmi (.aclk(aclk), .aresetn(aresetn), .fill(fill), .serve(serve),
        .slot_empty(slot_empty), .pending(pending));
    icm_mailbox i_icm_mailbox (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_resp(resp),
        .nmi_data_slot_empty(slot_empty), .nmi_pending(pending), .irq(irq));

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // =============================================
    // Bus tasks and comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input int c, input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        req[c].awvalid <= 1'b1;
        req[c].awaddr <= a;
        req[c].wvalid <= 1'b1;
        req[c].wdata <= d;
        req[c].wstrb <= 4'hF;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (req[c].awvalid && resp[c].awready === 1'b1)
            begin
                aw = 1'b1;
                req[c].awvalid <= 1'b0;
            end
            if (req[c].wvalid && resp[c].wready === 1'b1)
            begin
                w = 1'b1;
                req[c].wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (resp[c].bvalid !== 1'b1);
        req[c].bready <= 1'b1;
        @(posedge aclk);
        rsp = resp[c].bresp;
        req[c].bready <= 1'b0;
    endtask

    task automatic rd(input int c, input logic [7:0] a);
        req[c].arvalid <= 1'b1;
        req[c].araddr <= a;
        do @(posedge aclk); while (resp[c].arready !== 1'b1);
        req[c].arvalid <= 1'b0;
        do @(posedge aclk); while (resp[c].rvalid !== 1'b1);
        req[c].rready <= 1'b1;
        @(posedge aclk);
        rdat = resp[c].rdata;
        rsp = resp[c].rresp;
        req[c].rready <= 1'b0;
    endtask

    task automatic rdchk(input int c, input logic [7:0] a, input logic [31:0] exp);
        rd(c, a);
        check(rdat, exp);
    endtask

    // Core 0 writes its message on the edge where core 1's read lands
    task automatic collide(input logic [31:0] d);
        fork
            wr(0, 8'h04, d);
            begin
                @(posedge aclk);
                rd(1, 8'h10);
            end
        join
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            summarize();
        end
    end

    // =============================================
    // Main sequence
    initial
    begin
        req = '0;
        fill = 2'b00;
        serve = 2'b00;
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdchk(0, 8'h08, 32'h0);
        check({30'h0, irq}, 32'h0);
        fill <= 2'b10;
        @(posedge aclk);
        fill <= 2'b00;
        rdchk(0, 8'h00, 32'h2);
        serve <= 2'b10;
        @(posedge aclk);
        serve <= 2'b00;
        rdchk(0, 8'h00, 32'h4);
        $display("Test nmi mirror done");
        wr(0, 8'h08, 32'h9);
        wr(1, 8'h28, 32'h7);
        wr(0, 8'h04, 32'hFFA5A5C3);
        rdchk(0, 8'h08, 32'hB);
        rdchk(1, 8'h14, 32'hB);
        rdchk(1, 8'h20, 32'h1);
        check({30'h0, irq}, 32'h2);
        rdchk(1, 8'h10, 32'h00A5A5C3);
        rdchk(0, 8'h08, 32'h9);
        rdchk(0, 8'h0C, 32'h1);
        rdchk(0, 8'h20, 32'h2);
        wr(0, 8'h0C, 32'h2);
        rdchk(0, 8'h0C, 32'h0);
        $display("Test message done");
        wr(1, 8'h24, 32'h7);
        wr(0, 8'h08, 32'h0);
        wr(0, 8'h04, 32'h000123);
        rdchk(1, 8'h20, 32'h0);
        check({30'h0, irq}, 32'h0);
        rdchk(0, 8'h08, 32'h2);
        wr(1, 8'h10, 32'h00FFFFFF);
        wr(1, 8'h14, 32'hF);
        rdchk(1, 8'h10, 32'h000123);
        rdchk(0, 8'h08, 32'h0);
        rdchk(1, 8'h14, 32'h0);
        rd(0, 8'h30);
        check(rdat, 32'h0);
        check({30'h0, rsp}, {30'h0, `ICM_RESP_SLVERR});
        $display("Test disabled and read-only done");
        wr(1, 8'h08, 32'h8);
        collide(32'h000055);
        rdchk(1, 8'h08, 32'hC);
        rdchk(0, 8'h14, 32'hC);
        rdchk(0, 8'h08, 32'h0);
        rdchk(1, 8'h20, 32'h4);
        check({30'h0, irq}, 32'h2);
        wr(1, 8'h08, 32'hC);
        rdchk(1, 8'h08, 32'h8);
        wr(1, 8'h24, 32'h7);
        wr(1, 8'h08, 32'h0);
        collide(32'h0000AA);
        rdchk(1, 8'h20, 32'h0);
        wr(0, 8'h28, 32'h2);
        check({30'h0, irq}, 32'h1);
        $display("Test collision done");
        summarize();
    end
endmodule

`default_nettype wire
